// ==== pkg/adcfm_pkg.sv ====
// constants, types and state record for the adc frame and mode control block
package adcfm_pkg;

  // channel count and clocking
  localparam int  NCH_DEF        = 4;                 // channels on the wide variant
  localparam int  NCH_MAX        = 4;                 // storage width for channel vectors
  localparam real CLK_MHZ        = 200.0;             // system clock rate
  localparam real MOD_HR_MHZ     = 4.25;              // modulator ceiling, high resolution
  localparam real MOD_LP_MHZ     = 1.05;              // modulator ceiling, low power
  localparam int  HR_DIV         = $rtoi($ceil(CLK_MHZ / MOD_HR_MHZ)); // rounded up: never above ceiling
  localparam int  LP_DIV         = $rtoi($ceil(CLK_MHZ / MOD_LP_MHZ));
  localparam real POR_TIME_MS    = 4.5;               // longest power-on / reset sequence
  localparam int  POR_CYCLES_DEF = $rtoi(POR_TIME_MS * CLK_MHZ * 1000.0); // rounded down
  localparam int  OSR_DEF        = 32;                // modulator ticks per conversion

  // register byte addresses
  localparam logic [7:0] ADDR_ANALOG_CFG  = 8'h00;    // analog_system_config
  localparam logic [7:0] ADDR_DIGITAL_CFG = 8'h04;    // digital_system_config
  localparam logic [7:0] ADDR_CHAN_ENA    = 8'h08;    // channel_enable_reg
  localparam logic [7:0] ADDR_STATUS      = 8'h0C;    // state and strap readback

  // field positions
  localparam int HRM_BIT        = 0;                  // resolution_mode_select
  localparam int FIXED_BIT      = 0;                  // fixed-frame sizing
  localparam int CRC_BIT        = 1;                  // check word present
  localparam int STAT_STATE_LSB = 0;                  // two bits of state
  localparam int STAT_WOKEN     = 2;
  localparam int STAT_WL_LSB    = 3;                  // two bits of word length
  localparam int STAT_HAM       = 5;
  localparam int STAT_IMODE_LSB = 6;                  // two bits of interface mode strap
  localparam int STAT_PORF      = 8;
  localparam int STAT_FERR      = 9;                  // write one to clear

  // values after reset
  localparam logic HRM_RST   = 1'b1;
  localparam logic FIXED_RST = 1'b0;                  // dynamic-frame sizing
  localparam logic CRC_RST   = 1'b0;
  localparam logic [NCH_MAX-1:0] ENA_RST = 4'h0;

  // serial commands, sixteen bits
  localparam logic [15:0] CMD_NOP     = 16'h0000;
  localparam logic [15:0] CMD_RESET   = 16'h0011;
  localparam logic [15:0] CMD_STANDBY = 16'h0022;
  localparam logic [15:0] CMD_WAKEUP  = 16'h0033;
  localparam logic [15:0] CMD_LOCK    = 16'h0044;
  localparam logic [15:0] CMD_UNLOCK  = 16'h0055;
  localparam logic [3:0]  CMD_WREG    = 4'h4;         // [11:8] register, [7:0] data
  localparam logic [15:0] READY_WORD  = 16'hFF00;
  localparam logic [7:0]  STAT_TAG    = 8'h22;

  // last bit index of a word per length
  localparam logic [4:0] WL16_LAST = 5'h0F;
  localparam logic [4:0] WL24_LAST = 5'h17;
  localparam logic [4:0] WL32_LAST = 5'h1F;

  typedef enum logic [1:0] {WL16 = 2'b00, WL24 = 2'b01, WL32 = 2'b10} adcfm_wlen_e;
  typedef enum logic [1:0] {
    ST_POR = 2'b00, ST_LOCKED = 2'b01, ST_STANDBY = 2'b10, ST_AWAKE = 2'b11
  } adcfm_state_e;

  // serial pins into the device
  typedef struct packed {
    logic sclk;
    logic cs_n;
    logic mosi;
  } adcfm_spi_s;

  // strap pins; word length strap arrives as two level detectors
  typedef struct packed {
    logic       wl_high;
    logic       wl_low;
    logic       ham;
    logic [1:0] imode;
  } adcfm_strap_s;

  // whole state of the block
  typedef struct packed {
    logic sclk1, sclk2, sclk3, cs1, cs2, cs3, mosi1, mosi2;
    adcfm_strap_s strap1, strap2;
    adcfm_state_e state;
    logic [19:0] por_cnt;
    logic woken, frame_woken, in_frame;
    adcfm_wlen_e wl;
    logic ham, por_fault, resolution_mode_select, fixed, crc_en, frame_err, drdy_n, mod_tick, miso, miso_oe;
    logic [1:0] imode;
    logic [NCH_MAX-1:0] ena, chan_pwr;
    logic [7:0] mod_div, mod_gap;
    logic [11:0] osr_cnt;
    logic [NCH_MAX-1:0][23:0] result;
    logic [4:0] bit_pos;
    logic [2:0] word_idx, ch_ptr;
    logic [31:0] tx_sh, rx_sh;
    logic [15:0] cmd, resp;
    logic ah_we, ah_hit, hready_o, ready_o;
    logic [7:0] ah_addr;
    logic [31:0] hrdata;
  } adcfm_st_s;

endpackage : adcfm_pkg

// ==== rtl/adcfm_top.sv ====
// adc control: power-on, standby/wake, conversion pacing, serial framing, ahb-lite registers
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - resolution bit picks 4.25 or 1.05 MHz modulator
// - after reset, 4.5 ms sequence, straps, lock
// - one serial clock pulse wakes interface
// - ready word answers polls after power-on
// - unlocked device sits in standby, channels off
// - awake device converts continuously, results buffered
// - reset by pin or completed reset command
// - reset repeats power-on, then ready word
// - frame starts on chip select low
// - full duplex: commands in, status out
// - word length from strap, latched at the end of each reset sequence
// - fixed or dynamic sizing, dynamic default
// - fixed frame: status, every channel, check word
// - dynamic frame: status, enabled channels, optional check
// - frame size mismatch flags frame error
// - command in top sixteen bits, zeros below
// - first output word is sixteen-bit status
// - results truncated to sixteen bits when required
// - 24-bit hamming word: 16 data, 8 code
// - 32-bit word: 24 data, 8 code/zero
// - hamming strap enables protection, latched
module adcfm_top #(
  parameter int NCH        = adcfm_pkg::NCH_DEF,        // converter channels
  parameter int POR_CYCLES = adcfm_pkg::POR_CYCLES_DEF, // power-on length in clocks
  parameter int OSR        = adcfm_pkg::OSR_DEF         // modulator ticks per result
) (
  input  wire logic                  clock,       // system clock, 200 MHz
  input  wire logic                  reset_n,     // synchronous reset, active low
  input  wire logic                  hsel,        // ahb slave select
  input  wire logic [31:0]           haddr,       // ahb address
  input  wire logic [1:0]            htrans,      // ahb transfer type
  input  wire logic                  hwrite,      // ahb write
  input  wire logic [2:0]            hsize,       // ahb size, word only
  input  wire logic [31:0]           hwdata,      // ahb write data
  input  wire logic                  hready,      // ahb ready in
  output logic      [31:0]           hrdata,      // ahb read data
  output logic                       hreadyout,   // ahb ready out
  output logic                       hresp,       // ahb response, always okay
  input  wire adcfm_pkg::adcfm_spi_s spi,         // serial pins from host
  output logic                       miso,        // serial data to host
  output logic                       miso_oe,     // miso driven during a frame
  input  wire adcfm_pkg::adcfm_strap_s strap,     // strap pins
  input  wire logic                  init_fault,  // analog start-up fault flag
  input  wire logic [NCH-1:0][23:0]  chan_data,   // filter outputs per channel
  output logic                       drdy_n,      // data ready, active low
  output logic      [NCH-1:0]        chan_power,  // channel power enables
  output logic                       mod_tick,    // modulator clock strobe
  output logic                       ready        // power-on sequence done
);
  import adcfm_pkg::*;

  localparam logic [19:0] POR_LAST = 20'(POR_CYCLES - 1);
  localparam logic [11:0] OSR_LAST = 12'(OSR - 1);
  localparam logic [7:0]  HR_LAST  = 8'(HR_DIV - 1);
  localparam logic [7:0]  LP_LAST  = 8'(LP_DIV - 1);
  localparam logic [NCH_MAX-1:0] CH_MASK = NCH_MAX'((1 << NCH) - 1);

  adcfm_st_s   st;          // registered state
  adcfm_st_s   n;           // next state
  logic        sclk_rise;   // synchronised edges
  logic        sclk_fall;
  logic        cs_fall;
  logic        cs_rise;
  logic [4:0]  wl_last;     // last bit index of a word
  logic [2:0]  n_data;      // data words in this frame
  logic [2:0]  n_words;     // total words in this frame
  logic        frame_ok;    // frame closed on the expected size
  logic [15:0] stat16;      // live status word

  // edge finders look at the second and third stages only
  assign sclk_rise = st.sclk2 & ~st.sclk3;
  assign sclk_fall = ~st.sclk2 & st.sclk3;
  assign cs_fall   = ~st.cs2 & st.cs3;
  assign cs_rise   = st.cs2 & ~st.cs3;
  assign wl_last   = (st.wl == WL32) ? WL32_LAST : (st.wl == WL24) ? WL24_LAST : WL16_LAST;
  assign stat16    = {STAT_TAG, 4'h0, st.por_fault, st.frame_err, st.state};

  // frame sizing from mode, channel enables and check-word enable
  always_comb begin
    logic [2:0] cnt;
    cnt = 3'h0;
    for (int i = 0; i < NCH; i++) begin
      cnt = cnt + {2'b00, st.ena[i]};
    end
    if (st.fixed) begin
      n_data  = 3'(NCH);
      n_words = 3'(NCH + 2);
    end else begin
      n_data  = cnt;
      n_words = cnt + 3'h1 + {2'b00, st.crc_en};
    end
    frame_ok = (st.bit_pos == 5'h00) && (st.word_idx == n_words);
  end

  // next-state logic for the whole block
  always_comb begin
    logic [1:0]  sel;
    logic [31:0] word;
    logic [31:0] rx_new;
    logic [31:0] rd;
    logic [23:0] d;
    sel    = 2'b00;
    word   = 32'h0000_0000;
    rx_new = {st.rx_sh[30:0], st.mosi2};
    rd     = 32'h0000_0000;
    d      = 24'h00_0000;
    n      = st;
    // two-flop synchronisers for the serial and strap pins
    n.sclk1  = spi.sclk;
    n.sclk2  = st.sclk1;
    n.sclk3  = st.sclk2;
    n.cs1    = spi.cs_n;
    n.cs2    = st.cs1;
    n.cs3    = st.cs2;
    n.mosi1  = spi.mosi;
    n.mosi2  = st.mosi1;
    n.strap1 = strap;
    n.strap2 = st.strap1;
    n.mod_tick = 1'b0;

    // ahb address phase: capture decode, prepare read data
    n.ah_we = 1'b0;
    if (hsel && hready && htrans[1]) begin
      n.ah_we   = hwrite;
      n.ah_addr = haddr[7:0];
      n.ah_hit  = (haddr[31:4] == 28'h000_0000) && (haddr[1:0] == 2'b00);
      case (haddr[7:0])
        ADDR_ANALOG_CFG:  rd[HRM_BIT] = st.resolution_mode_select;
        ADDR_DIGITAL_CFG: begin
          rd[FIXED_BIT] = st.fixed;
          rd[CRC_BIT]   = st.crc_en;
        end
        ADDR_CHAN_ENA:    rd[NCH_MAX-1:0] = st.ena;
        ADDR_STATUS: begin
          rd[STAT_STATE_LSB +: 2] = st.state;
          rd[STAT_WOKEN]          = st.woken;
          rd[STAT_WL_LSB +: 2]    = st.wl;
          rd[STAT_HAM]            = st.ham;
          rd[STAT_IMODE_LSB +: 2] = st.imode;
          rd[STAT_PORF]           = st.por_fault;
          rd[STAT_FERR]           = st.frame_err;
        end
        default:          rd = 32'h0000_0000;  // unmapped reads zero
      endcase
      n.hrdata = (n.ah_hit && !hwrite) ? rd : 32'h0000_0000;
    end
    // ahb data phase write; registers hold defaults while resetting
    if (st.ah_we && st.ah_hit && st.state != ST_POR) begin
      case (st.ah_addr)
        ADDR_ANALOG_CFG:  n.resolution_mode_select = hwdata[HRM_BIT];
        ADDR_DIGITAL_CFG: begin
          n.fixed  = hwdata[FIXED_BIT];
          n.crc_en = hwdata[CRC_BIT];
        end
        ADDR_CHAN_ENA:    n.ena = hwdata[NCH_MAX-1:0] & CH_MASK;
        ADDR_STATUS:      if (hwdata[STAT_FERR]) n.frame_err = 1'b0;
        default:          n.ah_hit = st.ah_hit;               // ignored, still okay
      endcase
    end

    // any serial clock pulse after power-on wakes the interface
    if (sclk_rise && st.state != ST_POR) n.woken = 1'b1;

    // frame opens: snapshot wake state, restart counters
    if (cs_fall) begin
      n.in_frame    = 1'b1;
      n.miso_oe     = 1'b1;
      n.frame_woken = st.woken;
      n.bit_pos     = 5'h00;
      n.word_idx    = 3'h0;
      n.ch_ptr      = 3'h0;
      n.drdy_n      = 1'b1;
    end

    // shift out on the rising serial edge, loading words at boundaries
    if (st.in_frame && sclk_rise && st.frame_woken) begin
      if (st.bit_pos == 5'h00) begin
        if (st.word_idx == 3'h0) begin
          word = {st.resp, 16'h0000};
        end else if (st.word_idx <= n_data) begin
          for (int i = NCH - 1; i >= 0; i--) begin
            if (3'(i) >= st.ch_ptr && (st.fixed || st.ena[i])) sel = 2'(i);
          end
          n.ch_ptr = {1'b0, sel} + 3'h1;
          d = st.result[sel];
          case (st.wl)
            WL32:    word = {d, 8'h00};                       // code byte filled downstream
            WL24:    word = st.ham ? {d[23:8], 16'h0000} : {d, 8'h00};
            default: word = {d[23:8], 16'h0000};
          endcase
        end else begin
          word = 32'h0000_0000;  // check word slot; its value is produced elsewhere
        end
        n.miso  = word[31];
        n.tx_sh = {word[30:0], 1'b0};
      end else begin
        n.miso  = st.tx_sh[31];
        n.tx_sh = {st.tx_sh[30:0], 1'b0};
      end
    end

    // sample input on the falling serial edge
    if (st.in_frame && sclk_fall) begin
      n.rx_sh = rx_new;
      if (st.bit_pos == wl_last) begin
        n.bit_pos = 5'h00;
        if (st.word_idx != 3'h7) n.word_idx = st.word_idx + 3'h1;
        if (st.word_idx == 3'h0) begin
          case (st.wl)
            WL32:    n.cmd = rx_new[31:16];
            WL24:    n.cmd = rx_new[23:8];
            default: n.cmd = rx_new[15:0];
          endcase
        end
      end else begin
        n.bit_pos = st.bit_pos + 5'h01;
      end
    end

    // frame closes: a command acts only now, after it is complete
    if (st.in_frame && cs_rise) begin
      n.in_frame = 1'b0;
      n.miso_oe  = 1'b0;
      n.miso     = 1'b0;
      if (st.frame_woken) begin
        if (!frame_ok) begin
          n.frame_err = 1'b1;                                 // set beats clear
        end else begin
          case (st.state)
            ST_LOCKED: begin
              n.resp = READY_WORD;
              if (st.cmd == CMD_UNLOCK) begin
                n.state = ST_STANDBY;
                n.resp  = st.cmd;
              end else if (st.cmd == CMD_RESET) begin
                n.state   = ST_POR;
                n.por_cnt = 20'h0_0000;
              end
              // anything else is ignored while locked
            end
            ST_STANDBY, ST_AWAKE: begin
              n.resp = stat16;
              if (st.cmd == CMD_RESET) begin
                n.state   = ST_POR;
                n.por_cnt = 20'h0_0000;
              end else if (st.cmd == CMD_WAKEUP) begin
                n.state = ST_AWAKE;
                n.resp  = st.cmd;
              end else if (st.cmd == CMD_STANDBY) begin
                n.state = ST_STANDBY;
                n.resp  = st.cmd;
              end else if (st.cmd == CMD_LOCK) begin
                n.state = ST_LOCKED;
                n.resp  = st.cmd;
              end else if (st.cmd[15:12] == CMD_WREG) begin
                n.resp = st.cmd;
                case (st.cmd[11:8])
                  4'h0:    n.resolution_mode_select = st.cmd[HRM_BIT];
                  4'h1: begin
                    n.fixed  = st.cmd[FIXED_BIT];
                    n.crc_en = st.cmd[CRC_BIT];
                  end
                  4'h2:    n.ena = st.cmd[NCH_MAX-1:0] & CH_MASK;
                  default: n.resp = stat16;
                endcase
              end
            end
            default: n.resp = st.resp;
          endcase
        end
      end
    end

    // power-on / reset sequence: defaults held, straps caught at the end
    if (st.state == ST_POR) begin
      n.resolution_mode_select       = HRM_RST;
      n.fixed     = FIXED_RST;
      n.crc_en    = CRC_RST;
      n.ena       = ENA_RST;
      n.frame_err = 1'b0;
      n.woken     = 1'b0;
      if (st.por_cnt == POR_LAST) begin
        n.state     = ST_LOCKED;
        n.resp      = READY_WORD;
        n.wl        = st.strap2.wl_high ? WL32 : st.strap2.wl_low ? WL24 : WL16;
        n.ham       = st.strap2.ham;
        n.imode     = st.strap2.imode;
        n.por_fault = init_fault;
      end else begin
        n.por_cnt = st.por_cnt + 20'h0_0001;
      end
    end

    // continuous conversion pacing while awake
    if (st.state == ST_AWAKE) begin
      n.mod_gap = st.mod_tick ? 8'h00 : (st.mod_gap == 8'hFF) ? st.mod_gap : st.mod_gap + 8'h01;
      if (st.mod_div == (st.resolution_mode_select ? HR_LAST : LP_LAST)) begin
        n.mod_div  = 8'h00;
        n.mod_tick = 1'b1;
        if (st.osr_cnt == OSR_LAST) begin
          n.osr_cnt = 12'h000;
          n.drdy_n  = 1'b0;
          for (int i = 0; i < NCH; i++) begin
            n.result[i] = chan_data[i];                       // late frames may mix conversions
          end
        end else begin
          n.osr_cnt = st.osr_cnt + 12'h001;
        end
      end else begin
        n.mod_div = st.mod_div + 8'h01;
      end
    end else begin
      n.mod_div = 8'h00;
      n.osr_cnt = 12'h000;
      n.mod_gap = 8'h00;
    end
    // a mode switch restarts the divider so no short period escapes
    if (n.resolution_mode_select != st.resolution_mode_select) n.mod_div = 8'h00;
    // channels powered only while awake; ready kept in a flop, not decoded at the pin
    n.chan_pwr = (st.state == ST_AWAKE) ? st.ena : 4'h0;
    n.ready_o  = (n.state != ST_POR);
  end

  // state register
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      st          <= '0;
      st.state    <= ST_POR;
      st.resolution_mode_select      <= HRM_RST;
      st.drdy_n   <= 1'b1;
      st.cs1      <= 1'b1;
      st.cs2      <= 1'b1;
      st.cs3      <= 1'b1;
      st.hready_o <= 1'b1;
      st.wl       <= WL16;
    end else begin
      st <= n;
    end
  end

  // outputs straight from the state register, hresp tied to okay
  assign hrdata     = st.hrdata;
  assign hreadyout  = st.hready_o;
  assign hresp      = 1'b0;
  assign miso       = st.miso;
  assign miso_oe    = st.miso_oe;
  assign drdy_n     = st.drdy_n;
  assign chan_power = st.chan_pwr[NCH-1:0];
  assign mod_tick   = st.mod_tick;
  assign ready      = st.ready_o;

  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  sequence seq_frame_close;
    st.in_frame && cs_rise && st.frame_woken;
  endsequence
  sequence seq_por_exit;
    st.state == ST_POR && st.por_cnt == POR_LAST ##1 st.state == ST_LOCKED;
  endsequence

  chk_mod_rate: assert property (st.mod_tick |-> st.mod_gap >= (st.resolution_mode_select ? HR_LAST : LP_LAST))
    else $error("modulator strobe faster than mode allows");
  chk_por_exit: assert property ((st.state == ST_LOCKED && $past(st.state) == ST_POR)
    |-> $past(st.por_cnt) == POR_LAST && !st.woken)
    else $error("power-on ended early or interface not asleep");
  chk_ready_word: assert property (seq_por_exit |-> st.resp == READY_WORD)
    else $error("ready word not loaded after reset sequence");
  chk_sleep_frame: assert property ((st.in_frame && cs_rise && !st.frame_woken)
    |=> st.state == $past(st.state) && st.frame_err == $past(st.frame_err))
    else $error("frame acted before wake pulse");
  chk_lock_filter: assert property ((seq_frame_close and st.state == ST_LOCKED)
    ##0 (st.cmd != CMD_UNLOCK && st.cmd != CMD_RESET) |=> st.state == ST_LOCKED)
    else $error("locked interface obeyed a command");
  chk_standby_off: assert property (st.state != ST_AWAKE |=> st.chan_pwr == 4'h0)
    else $error("channel powered outside awake state");
  chk_cmd_reset: assert property ((seq_frame_close ##0 frame_ok && st.cmd == CMD_RESET
    && st.state != ST_POR) |=> st.state == ST_POR ##1 st.ena == ENA_RST && !st.fixed)
    else $error("reset command did not restart to defaults");
  chk_strap_held: assert property ((st.state != ST_POR && $past(st.state) != ST_POR)
    |-> $stable(st.wl) && $stable(st.ham))
    else $error("strap settings changed after latch");
  chk_frame_size: assert property ((seq_frame_close ##0 !frame_ok) |=> st.frame_err)
    else $error("frame size mismatch not flagged");
  chk_conv_ready: assert property ((st.state == ST_AWAKE && st.mod_div == (st.resolution_mode_select ? HR_LAST : LP_LAST)
    && st.osr_cnt == OSR_LAST) |=> !st.drdy_n && st.mod_tick)
    else $error("finished conversion without data ready");

endmodule : adcfm_top
`default_nettype wire

// ==== bench/adcfm_host_model.sv ====
// host serial master model that clocks frames into the adc block
`timescale 1ns/1ps
`default_nettype none
module adcfm_host_model (
  output var adcfm_pkg::adcfm_spi_s spi,  // serial pins to device
  input  wire logic                 miso  // serial data from device
);
  import adcfm_pkg::*;
  initial spi = 3'b010;  // clock still, deselected
  // one frame of n bits, first bit tx[n-1]; clock stands still between frames
  task automatic xfer(input int n, input logic [159:0] tx, output logic [159:0] rx);
    rx = '0;
    spi.cs_n = 1'b0;  // frame opens
    #40;
    for (int i = n - 1; i >= 0; i--) begin
      spi.mosi = tx[i];
      spi.sclk = 1'b1;  // first rise also wakes the interface
      #40;
      spi.sclk = 1'b0;
      rx[i] = miso;  // device output taken on the fall
      #40;
    end
    spi.cs_n = 1'b1;
    spi.mosi = ~spi.mosi;  // released line shows no stale level
    #100;
  endtask : xfer
endmodule : adcfm_host_model
`default_nettype wire

// ==== bench/adc_spi_frame_and_mode_control_test.sv ====
// bench: power-on, lock, wake, frame data, frame error, reset command
`timescale 1ns/1ps
`default_nettype none
module adc_spi_frame_and_mode_control_test;
  import adcfm_pkg::*;
  logic         clock = 1'b0, reset_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [1:0]   htrans = 2'b00;
  logic [31:0]  haddr = '0, hwdata = '0, hrdata, q;
  logic         hreadyout, hresp, miso, miso_oe, drdy_n, mod_tick, ready;
  logic [3:0]   chan_power;
  logic [159:0] rx;
  adcfm_spi_s   spi;
  adcfm_strap_s strap = 5'b10100;  // 32-bit words, hamming on
  logic         init_fault = 1'b0;
  logic [3:0][23:0] chan_data = {24'h4D2E1F, 24'h3C1D0E, 24'h2B0CFD, 24'h1A2B3C};
  int           n_errors = 0, total_checks = 0, cyc = 0, gap = 0;
  always #2.5 clock = ~clock;  // 200 MHz
  adcfm_host_model host (.spi(spi), .miso(miso));
  // short power-on and oversampling keep the run brief
  adcfm_top #(.NCH(4), .POR_CYCLES(50), .OSR(2)) dut (
    .clock(clock), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .spi(spi), .miso(miso), .miso_oe(miso_oe), .strap(strap), .init_fault(init_fault),
    .chan_data(chan_data), .drdy_n(drdy_n),
    .chan_power(chan_power), .mod_tick(mod_tick), .ready(ready));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic tally_and_finish;
    $display("checks=%0d errors=%0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : tally_and_finish
  // one ahb single word; read data lands in q
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clock);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    do @(posedge clock); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge clock); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask : ahb
  task automatic fr(input int n, input logic [15:0] c);
    host.xfer(n, 160'({c, 16'h0000}) << (n - 32), rx);  // low bits zero
  endtask : fr
  task automatic wait_ready;
    for (int i = 0; i < 200 && ready !== 1'b1; i++) @(posedge clock);
  endtask : wait_ready
  // clock edges between two modulator strobes
  task automatic tick_gap(output int g);
    for (int i = 0; i < 400 && mod_tick !== 1'b1; i++) @(posedge clock);
    g = 0;
    do begin
      @(posedge clock);
      g++;
    end while (mod_tick !== 1'b1 && g < 400);
  endtask : tick_gap
  // hang guard
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_errors++;
      tally_and_finish;
    end
  end
  initial begin
    repeat (4) @(posedge clock);
    reset_n <= 1'b1;
    ahb(1'b0, 32'h0, 32'h0);
    chk(q, 32'h1);
    chk(hresp, 32'h0);  // okay response
    ahb(1'b0, 32'h10, 32'h0);
    chk(q, 32'h0);  // unmapped reads zero
    wait_ready();
    ahb(1'b0, 32'hC, 32'h0);
    chk(q & 32'h3F, 32'h31);
    strap <= 5'b01000;  // later change must not reach the latched setting
    fr(32, CMD_NOP);
    fr(32, 16'h4101);  // write tried while locked
    fr(32, CMD_UNLOCK);  // host unlocks after the refused write
    chk(rx[31:16], READY_WORD);
    chk(miso_oe, 32'h0);  // output released after the frame
    ahb(1'b0, 32'h4, 32'h0);
    chk(q, 32'h0);
    ahb(1'b0, 32'hC, 32'h0);
    chk(q & 32'h7, 32'h6);
    chk(q[4:3], 32'h2);  // still 32-bit words
    chk(chan_power, 32'h0);
    ahb(1'b1, 32'h8, 32'hF);  // all channels together
    fr(160, CMD_WAKEUP);
    chk(rx[159:128], 32'h0055_0000);
    chk(chan_power, 32'hF);
    tick_gap(gap);
    chk(gap, HR_DIV);  // strobe spacing, high resolution
    ahb(1'b1, 32'h0, 32'h0);  // low-power mode
    tick_gap(gap);  // first gap may straddle the switch
    tick_gap(gap);
    chk(gap, LP_DIV);
    for (int i = 0; i < 2000 && drdy_n !== 1'b0; i++) @(posedge clock);
    chk(drdy_n, 32'h0);
    fr(160, CMD_NOP);  // five words: status and four channels
    chk(rx[159:128], 32'h0033_0000);
    chk(rx[127:96], 32'h1A2B3C00);
    chk(rx[31:0], 32'h4D2E1F00);
    fr(32, CMD_NOP);  // too short now
    ahb(1'b0, 32'hC, 32'h0);
    chk(q[9], 32'h1);
    fr(160, CMD_STANDBY);  // stop: standby first
    chk(rx[159:128], 32'h2203_0000);  // awake status word
    chk(chan_power, 32'h0);
    ahb(1'b1, 32'h8, 32'h0);  // then clear the enables
    ahb(1'b1, 32'hC, 32'h200);  // write one clears frame error
    ahb(1'b0, 32'hC, 32'h0);
    chk(q[9], 32'h0);
    ahb(1'b1, 32'h8, 32'h3);  // two channels: three-word frames
    fr(96, CMD_LOCK);
    chk(rx[95:80], CMD_STANDBY);
    init_fault <= 1'b1;  // start-up fault for the next reset sequence
    fr(96, CMD_RESET);  // reset taken while locked
    chk(rx[95:80], CMD_LOCK);
    chk(ready, 32'h0);
    wait_ready();
    ahb(1'b0, 32'h8, 32'h0);
    chk(q, 32'h0);
    ahb(1'b0, 32'hC, 32'h0);
    chk(q & 32'h3, 32'h1);
    chk(q[4:3], 32'h1);  // straps caught again
    chk(q[8], 32'h1);
    ahb(1'b0, 32'h0, 32'h0);
    chk(q, 32'h1);
    tally_and_finish();
  end
endmodule : adc_spi_frame_and_mode_control_test
`default_nettype wire
